// >>> src/fifo_device_end.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Dual-clock buffer with programmable flags
// ----------------------------------------------------------------------
module fifo_device_end
   import fifo_pkg::*;
(
   // Clocks, reset and enable
   input  wire logic wr_clk_in,
   input  wire logic rd_clk_in,
   input  wire logic nrst_in,
   input  wire logic ce_in,
   // Writer and reader side
   fifo_link_if.dev  link
);

   // ------------------------------------------------------------------
   // Storage and shared state
   // ------------------------------------------------------------------
   logic [DATA_W-1:0] mem [DEPTH];
   logic              clr_n;
   logic [PW-1:0]     wbin;
   logic [PW-1:0]     wgray;
   logic [PW-1:0]     rbin;
   logic [PW-1:0]     rgray;
   logic [PW-1:0]     rgray_w;
   logic [PW-1:0]     wgray_r;
   logic [PW-1:0]     next_wbin;
   logic [PW-1:0]     next_rbin;
   logic [PW-1:0]     wcount;
   logic [PW-1:0]     rcount;
   logic [PW-1:0]     free_space;
   logic [OFF_W-1:0]  empty_distance_offset;
   logic [OFF_W-1:0]  full_distance_offset;
   logic              wsel;
   logic              rsel;
   logic              wr_go;
   logic              rd_go;
   logic              prog_w;
   logic              prog_r;

   // The pin clear and the system reset act alike, without a clock.
   assign clr_n = nrst_in & link.fifo_clear_n;

   // ------------------------------------------------------------------
   // Pointer crossings
   // ------------------------------------------------------------------
   // Only one bit of a gray pointer moves per increment, so a sample taken
   // mid-change is either the old or the new value; only the replay jump of rgray to zero can be caught as a mix.
   sync2 #(.W(PW)) u_rptr_to_w (
      .clk_in   (wr_clk_in),
      .nrst_in  (clr_n),
      .ce_in    (ce_in),
      .async_in (rgray),
      .sync_out (rgray_w)
   );

   sync2 #(.W(PW)) u_wptr_to_r (
      .clk_in   (rd_clk_in),
      .nrst_in  (clr_n),
      .ce_in    (ce_in),
      .async_in (wgray),
      .sync_out (wgray_r)
   );

   // ------------------------------------------------------------------
   // Write domain
   // ------------------------------------------------------------------
   assign wr_go = ce_in & ~link.wr_en_n & link.offset_load_n
                  & link.full_flag_n;
   assign prog_w = ce_in & ~link.wr_en_n & ~link.offset_load_n;
   assign next_wbin = wr_go ? PW'(wbin + 1'b1) : wbin;
   // The read pointer seen here is two edges old, which is what may
   // hold the full flag two extra edges after a close read.
   assign wcount = PW'(next_wbin - gray2bin(rgray_w));
   assign free_space = PW'(DEPTH_P - wcount);

   always_ff @(posedge wr_clk_in) begin
      if (wr_go) begin
         mem[wbin[AW-1:0]] <= link.d;
      end
   end

   always_ff @(posedge wr_clk_in or negedge clr_n) begin
      if (!clr_n) begin
         wbin  <= '0;
         wgray <= '0;
      end else if (ce_in) begin
         wbin  <= next_wbin;
         wgray <= next_wbin ^ (next_wbin >> 1);
      end
   end

   // Full, half and almost-full all move on write edges only.
   always_ff @(posedge wr_clk_in or negedge clr_n) begin
      if (!clr_n) begin
         link.full_flag_n   <= 1'b1;
         link.half_full_n   <= 1'b1;
         link.almost_full_n <= 1'b1;
      end else if (ce_in) begin
         link.full_flag_n   <= (wcount != DEPTH_P);
         link.half_full_n   <= !(wcount > HALF_P);
         link.almost_full_n <=
            !(free_space <= {1'b0, full_distance_offset});
      end
   end

   // Offset loads alternate; releasing the load strobe keeps position.
   always_ff @(posedge wr_clk_in or negedge clr_n) begin
      if (!clr_n) begin
         empty_distance_offset <= OFFSET_RESET;
         full_distance_offset  <= OFFSET_RESET;
         wsel                  <= 1'b0;
      end else if (prog_w) begin
         if (!wsel) begin
            empty_distance_offset <= link.d[OFF_W-1:0];
         end else begin
            full_distance_offset <= link.d[OFF_W-1:0];
         end
         wsel <= ~wsel;
      end
   end

   // ------------------------------------------------------------------
   // Read domain
   // ------------------------------------------------------------------
   assign rd_go = ce_in & ~link.rd_en_n & link.offset_load_n
                  & link.empty_flag_n & ~link.replay_pulse;
   assign prog_r = ce_in & ~link.rd_en_n & ~link.offset_load_n;

   always_comb begin
      next_rbin = rbin;
      if (link.replay_pulse) begin
         next_rbin = '0;
      end else if (rd_go) begin
         next_rbin = PW'(rbin + 1'b1);
      end
   end

   assign rcount = PW'(gray2bin(wgray_r) - next_rbin);

   always_ff @(posedge rd_clk_in or negedge clr_n) begin
      if (!clr_n) begin
         rbin  <= '0;
         rgray <= '0;
      end else if (ce_in) begin
         rbin  <= next_rbin;
         rgray <= next_rbin ^ (next_rbin >> 1);
      end
   end

   // Empty and almost-empty move on read edges only; after a replay
   // they settle on the same edge that loads the rewound pointer.
   always_ff @(posedge rd_clk_in or negedge clr_n) begin
      if (!clr_n) begin
         link.empty_flag_n   <= 1'b0;
         link.almost_empty_n <= 1'b0;
      end else if (ce_in) begin
         link.empty_flag_n   <= (rcount != '0);
         link.almost_empty_n <=
            !(rcount <= {1'b0, empty_distance_offset});
      end
   end

   // The offsets are read across the clock boundary; they only change
   // while the load strobe is low, so the reader must not load and
   // read them in the same cycle.
   always_ff @(posedge rd_clk_in or negedge clr_n) begin
      if (!clr_n) begin
         link.q <= '0;
         rsel   <= 1'b0;
      end else if (rd_go) begin
         link.q <= mem[rbin[AW-1:0]];
      end else if (prog_r) begin
         link.q <= rsel ? DATA_W'(full_distance_offset)
                        : DATA_W'(empty_distance_offset);
         rsel   <= ~rsel;
      end
   end

   always_ff @(posedge rd_clk_in or negedge clr_n) begin
      if (!clr_n) begin
         link.q_oe <= 1'b0;
      end else if (ce_in) begin
         link.q_oe <= ~link.output_enable_n;
      end
   end

endmodule
`default_nettype wire

// >>> src/fifo_pkg.sv
// ----------------------------------------------------------------------
// Shared constants for the dual-clock buffer and its host end
// ----------------------------------------------------------------------
package fifo_pkg;

   // Store geometry.
   localparam int DATA_W = 18;
   localparam int AW     = 14;
   localparam int PW     = 15;
   localparam int OFF_W  = 14;
   localparam int DEPTH  = 16384;
   localparam logic [PW-1:0] DEPTH_P = 15'h4000;
   localparam logic [PW-1:0] HALF_P  = 15'h2000;
   localparam logic [OFF_W-1:0] OFFSET_RESET = 14'h007F;

   // Replay timing.
   localparam int CLK_PERIOD_NS      = 10;
   localparam int REPLAY_PULSE_NS    = 30;
   localparam int REPLAY_RECOVERY_NS = 60;
   localparam logic [3:0] PULSE_CYC =
      4'((REPLAY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] RECOVERY_CYC =
      4'((REPLAY_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Host register map, byte addresses.
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] WDATA_ADDR  = 8'h04;
   localparam logic [7:0] RCMD_ADDR   = 8'h08;
   localparam logic [7:0] REPLAY_ADDR = 8'h0C;
   localparam logic [7:0] STATUS_ADDR = 8'h10;
   localparam logic [7:0] RDATA_ADDR  = 8'h14;

   // Field positions.
   localparam int CTRL_CLEAR_BIT = 0;
   localparam int CTRL_OE_BIT    = 1;
   localparam int CTRL_SYNC_BIT  = 2;
   localparam int WDATA_LOAD_BIT = 18;
   localparam int RCMD_LOAD_BIT  = 0;
   localparam int STATUS_BUSY_BIT = 5;
   localparam logic [2:0] CTRL_RESET = 3'h0;

   typedef enum logic [1:0] {RP_IDLE, RP_PULSE, RP_RECOVER} replay_state_e;

   function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
      logic [PW-1:0] b;
      b[PW-1] = g[PW-1];
      // The top bit is handled apart so no select reaches past the MSB.
      for (int i = PW - 2; i >= 0; i--) begin
         b[i] = g[i] ^ b[i+1];
      end
      return b;
   endfunction

endpackage

// >>> src/fifo_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Link between the buffer and its writer/reader
// ----------------------------------------------------------------------
interface fifo_link_if;
   import fifo_pkg::*;
   logic              fifo_clear_n;
   logic              wr_en_n;
   logic              rd_en_n;
   logic              output_enable_n;
   logic              offset_load_n;
   logic              replay_pulse;
   logic              flag_sync_select_n;
   logic [DATA_W-1:0] d;
   logic [DATA_W-1:0] q;
   logic              q_oe;
   logic              empty_flag_n;
   logic              full_flag_n;
   logic              half_full_n;
   logic              almost_empty_n;
   logic              almost_full_n;

   modport dev (
      input  fifo_clear_n, wr_en_n, rd_en_n, output_enable_n,
      input  offset_load_n, replay_pulse, flag_sync_select_n, d,
      output q, q_oe, empty_flag_n, full_flag_n, half_full_n,
      output almost_empty_n, almost_full_n
   );

   modport host (
      output fifo_clear_n, wr_en_n, rd_en_n, output_enable_n,
      output offset_load_n, replay_pulse, flag_sync_select_n, d,
      input  q, q_oe, empty_flag_n, full_flag_n, half_full_n,
      input  almost_empty_n, almost_full_n
   );
endinterface
`default_nettype wire

// >>> src/sync2.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Two-stage synchroniser for a bus that changes one bit at a time
// ----------------------------------------------------------------------
module sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         nrst_in,
   input  wire logic         ce_in,
   // Data
   input  wire logic [W-1:0] async_in,
   output var  logic [W-1:0] sync_out
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta     <= '0;
         sync_out <= '0;
      end else if (ce_in) begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

// >>> src/fifo_host_end.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Writer/reader end, driven by software over APB
// ----------------------------------------------------------------------
module fifo_host_end
   import fifo_pkg::*;
(
   // Clock, reset and enable
   input  wire logic        ref_clk_in,
   input  wire logic        nrst_in,
   input  wire logic        ce_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output var  logic [31:0] prdata_out,
   output var  logic        pready_out,
   output var  logic        pslverr_out,
   // Buffer side
   fifo_link_if.host        link
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic [2:0]        ctrl;
   logic [3:0]        rp_cnt;
   replay_state_e     rp_state;
   logic              busy;
   logic              setup;
   logic              wr_acc;
   logic [22:0]       stat_sync;
   logic [31:0]       next_rdata;
   logic              next_err;

   sync2 #(.W(23)) u_stat_sync (
      .clk_in   (ref_clk_in),
      .nrst_in  (nrst_in),
      .ce_in    (ce_in),
      .async_in ({link.q, link.empty_flag_n, link.full_flag_n,
                  link.half_full_n, link.almost_empty_n,
                  link.almost_full_n}),
      .sync_out (stat_sync)
   );

   // Buffer writes and read commands are refused while clearing or replaying.
   assign busy   = (rp_state != RP_IDLE) | ctrl[CTRL_CLEAR_BIT];
   assign setup  = psel_in & ~penable_in;
   assign wr_acc = psel_in & penable_in & pready_out & pwrite_in;

   // ------------------------------------------------------------------
   // APB answer: no wait states, data latched in the setup cycle
   // ------------------------------------------------------------------
   always_comb begin
      next_rdata = '0;
      next_err   = 1'b0;
      unique case (paddr_in)
         CTRL_ADDR:   next_rdata = 32'(ctrl);
         STATUS_ADDR: begin
            next_rdata                  = 32'(stat_sync[4:0]);
            next_rdata[STATUS_BUSY_BIT] = busy;
         end
         RDATA_ADDR:  next_rdata = 32'(stat_sync[22:5]);
         WDATA_ADDR, RCMD_ADDR, REPLAY_ADDR: next_rdata = '0;
         default:     next_err = 1'b1;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pready_out  <= 1'b0;
         prdata_out  <= '0;
         pslverr_out <= 1'b0;
      end else if (ce_in) begin
         pready_out <= setup;
         if (setup) begin
            prdata_out  <= pwrite_in ? 32'h00000000 : next_rdata;
            pslverr_out <= next_err;
         end
      end
   end

   // ------------------------------------------------------------------
   // Control and command strobes
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctrl               <= CTRL_RESET;
         link.fifo_clear_n  <= 1'b1;
         link.output_enable_n    <= 1'b1;
         link.flag_sync_select_n <= 1'b1;
         link.wr_en_n       <= 1'b1;
         link.rd_en_n       <= 1'b1;
         link.offset_load_n <= 1'b1;
         link.d             <= '0;
      end else if (ce_in) begin
         link.fifo_clear_n       <= ~ctrl[CTRL_CLEAR_BIT];
         link.output_enable_n    <= ~ctrl[CTRL_OE_BIT];
         link.flag_sync_select_n <= ~ctrl[CTRL_SYNC_BIT];
         link.wr_en_n       <= 1'b1;
         link.rd_en_n       <= 1'b1;
         link.offset_load_n <= 1'b1;
         if (wr_acc && paddr_in == CTRL_ADDR) begin
            ctrl <= pwdata_in[2:0];
         end
         if (wr_acc && paddr_in == WDATA_ADDR && !busy) begin
            link.wr_en_n       <= 1'b0;
            link.d             <= pwdata_in[DATA_W-1:0];
            link.offset_load_n <= ~pwdata_in[WDATA_LOAD_BIT];
         end
         if (wr_acc && paddr_in == RCMD_ADDR && !busy) begin
            link.rd_en_n       <= 1'b0;
            link.offset_load_n <= ~pwdata_in[RCMD_LOAD_BIT];
         end
      end
   end

   // ------------------------------------------------------------------
   // Replay pulse and recovery
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rp_state          <= RP_IDLE;
         rp_cnt            <= '0;
         link.replay_pulse <= 1'b0;
      end else if (ce_in) begin
         unique case (rp_state)
            RP_IDLE: begin
               if (wr_acc && paddr_in == REPLAY_ADDR
                   && !ctrl[CTRL_CLEAR_BIT]) begin
                  rp_state          <= RP_PULSE;
                  rp_cnt            <= PULSE_CYC;
                  link.replay_pulse <= 1'b1;
               end
            end
            RP_PULSE: begin
               if (rp_cnt == 4'h1) begin
                  rp_state          <= RP_RECOVER;
                  rp_cnt            <= RECOVERY_CYC;
                  link.replay_pulse <= 1'b0;
               end else begin
                  rp_cnt <= rp_cnt - 4'h1;
               end
            end
            RP_RECOVER: begin
               if (rp_cnt == 4'h1) begin
                  rp_state <= RP_IDLE;
               end else begin
                  rp_cnt <= rp_cnt - 4'h1;
               end
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// >>> testbench/fifo_link_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// Link checker
// ------------------------------
module fifo_link_asserts
   import fifo_pkg::*;
(
   // Clock and reset
   input wire logic              ref_clk_in,
   input wire logic              nrst_in,
   // Host to device
   input wire logic              fifo_clear_n,
   input wire logic              wr_en_n,
   input wire logic              rd_en_n,
   input wire logic              output_enable_n,
   input wire logic              offset_load_n,
   // Device to host
   input wire logic [DATA_W-1:0] q,
   input wire logic              q_oe,
   input wire logic              empty_flag_n,
   input wire logic              full_flag_n,
   input wire logic              half_full_n,
   input wire logic              almost_empty_n,
   input wire logic              almost_full_n
);
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!nrst_in);

   a_clear_flags: assert property (
      !fifo_clear_n |=> !empty_flag_n && !almost_empty_n && full_flag_n
      && half_full_n && almost_full_n)
      else $error("flags not at cleared state");
   a_clear_q: assert property (
      !fifo_clear_n |=> q == '0)
      else $error("output word not low after clear");
   a_oe_follow: assert property (
      fifo_clear_n && $past(fifo_clear_n)
      |-> q_oe == !$past(output_enable_n))
      else $error("drive enable does not follow output enable");
   a_empty_state: assert property (
      !empty_flag_n |-> !almost_empty_n && half_full_n && full_flag_n)
      else $error("flags disagree with empty");
   a_full_state: assert property (
      !full_flag_n |-> !half_full_n && !almost_full_n && empty_flag_n)
      else $error("flags disagree with full");
   a_q_on_read: assert property (
      $changed(q) && fifo_clear_n && $past(fifo_clear_n)
      |-> !$past(rd_en_n))
      else $error("output word moved without a read");
   a_empty_hold: assert property (
      !empty_flag_n && fifo_clear_n && offset_load_n
      |=> $stable(q) || !fifo_clear_n)
      else $error("output word moved while empty");
   a_full_fall: assert property (
      $fell(full_flag_n) |-> !$past(wr_en_n) || !$past(wr_en_n, 2)
      || !$past(wr_en_n, 3))
      else $error("full asserted without a write");
   a_empty_fall: assert property (
      $fell(empty_flag_n) && fifo_clear_n |-> !$past(rd_en_n)
      || !$past(rd_en_n, 2) || !$past(rd_en_n, 3))
      else $error("empty asserted without a read");

   c_full: cover property ($fell(full_flag_n));
   c_data: cover property ($rose(empty_flag_n));
   c_oe: cover property ($rose(q_oe));
endmodule
`default_nettype wire

// >>> testbench/dual_clock_fifo_prog_flags_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module dual_clock_fifo_prog_flags_tb_top
   import fifo_pkg::*;
;
   typedef struct {
      logic        err;
      logic [31:0] v;
      logic [31:0] m;
   } note_s;

   logic        ref_clk;
   logic        nrst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   note_s       notes[$];
   logic [31:0] wq[$];
   int          num_errors = 0;
   int          checks = 0;
   int          seed = 79;
   int          ne;
   int          nf;

   fifo_link_if link ();
   fifo_device_end u_fifo_device_end (.wr_clk_in(ref_clk),
      .rd_clk_in(ref_clk), .nrst_in(nrst), .ce_in(1'b1), .link(link));
   fifo_host_end u_fifo_host_end (.ref_clk_in(ref_clk), .nrst_in(nrst),
      .ce_in(1'b1), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .link(link));
   fifo_link_asserts u_fifo_link_asserts (.ref_clk_in(ref_clk),
      .nrst_in(nrst), .fifo_clear_n(link.fifo_clear_n),
      .wr_en_n(link.wr_en_n), .rd_en_n(link.rd_en_n),
      .output_enable_n(link.output_enable_n),
      .offset_load_n(link.offset_load_n), .q(link.q), .q_oe(link.q_oe),
      .empty_flag_n(link.empty_flag_n), .full_flag_n(link.full_flag_n),
      .half_full_n(link.half_full_n),
      .almost_empty_n(link.almost_empty_n),
      .almost_full_n(link.almost_full_n));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // ------------------------------
   // Bus tasks
   // ------------------------------
   // An idle cycle follows each transfer so psel is never set twice in
   // one time step.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         num_errors++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] v,
                     input logic [31:0] m, input logic e = 1'b0);
      notes.push_back('{e, v, m});
      apb(1'b0, a, 32'h0);
   endtask

   // Flags need three edges plus two host sync stages to show.
   task automatic settle();
      repeat (10) @(posedge ref_clk);
   endtask

   function automatic logic [31:0] st(int c);
      return {27'h0, c != 0, c != DEPTH, c <= DEPTH / 2, c > ne,
              DEPTH - c > nf};
   endfunction

   task automatic stat(input int c, input logic [31:0] m);
      settle();
      rd(STATUS_ADDR, st(c), m);
   endtask

   task automatic pop_word(input logic [31:0] v);
      apb(1'b1, RCMD_ADDR, 32'h0);
      settle();
      rd(RDATA_ADDR, v, 32'h3FFFF);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      note_s n;
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         n = notes.pop_front();
         checks++;
         if ({pslverr, prdata & n.m} !== {n.err, n.v & n.m}) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time,
                     {pslverr, prdata & n.m}, {n.err, n.v & n.m});
         end
      end
   end

   // ------------------------------
   // Tests
   // ------------------------------
   initial begin
      int i;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      nrst = 1'b0;
      ne = 127;
      nf = 127;
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      stat(0, 32'h1F);
      rd(8'h18, 32'h0, 32'hFFFFFFFF, 1'b1);
      apb(1'b1, CTRL_ADDR, 32'h6);
      for (i = 0; i < 2; i++) begin
         apb(1'b1, RCMD_ADDR, 32'h1);
         settle();
         rd(RDATA_ADDR, 32'h7F, 32'h3FFFF);
      end
      $display("test reset and default offsets done");
      for (i = 1; i <= DEPTH + 1; i++) begin
         apb(1'b1, WDATA_ADDR, 32'(i - 1) ^ 32'h2AAAA);
         if (i inside {1, 127, 128, 8192, 8193, 16256, 16257, 16384,
                       16385}) begin
            stat(i > DEPTH ? DEPTH : i, 32'h1F);
         end
      end
      pop_word(32'h2AAAA);
      stat(DEPTH - 1, 32'h1F);
      $display("test fill to full done");
      apb(1'b1, CTRL_ADDR, 32'h7);
      apb(1'b1, CTRL_ADDR, 32'h6);
      stat(0, 32'h1F);
      rd(RDATA_ADDR, 32'h0, 32'h3FFFF);
      ne = 2 + ($random(seed) & 3);
      nf = $random(seed) & 32'h3FFF;
      apb(1'b1, WDATA_ADDR, 32'h40000 | ne);
      for (i = 1; i <= ne + 2; i++) begin
         wq.push_back($random(seed) & 32'h3FFFF);
         apb(1'b1, WDATA_ADDR, wq[i - 1]);
         stat(i, 32'h1E);
      end
      apb(1'b1, WDATA_ADDR, 32'h40000 | nf);
      stat(ne + 2, 32'h1F);
      for (i = 0; i < 2; i++) begin
         apb(1'b1, RCMD_ADDR, 32'h1);
         settle();
         rd(RDATA_ADDR, i == 0 ? ne : nf, 32'h3FFFF);
      end
      foreach (wq[j]) begin
         pop_word(wq[j]);
      end
      pop_word(wq[wq.size() - 1]);
      stat(0, 32'h1F);
      $display("test offsets and data done");
      apb(1'b1, REPLAY_ADDR, 32'h1);
      rd(STATUS_ADDR, 32'h20, 32'h20);
      // Refused while replay recovery runs; the later pop_word reads prove it.
      apb(1'b1, WDATA_ADDR, 32'h15555);
      repeat (2) settle();
      wq.push_back($random(seed) & 32'h3FFFF);
      apb(1'b1, WDATA_ADDR, wq[ne + 2]);
      stat(ne + 3, 32'h1F);
      foreach (wq[j]) begin
         pop_word(wq[j]);
      end
      $display("test replay done");
      print_verdict();
   end

   initial begin
      repeat (90000) @(posedge ref_clk);
      num_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
